// >>> logic/sram_host_ctrl.sv
// Host controller that drives the 128K x 32 asynchronous SRAM module pins
`timescale 1ns/100ps
module sram_host_ctrl (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic reqValid,
    output logic reqReady,
    input wire logic reqWrite,
    input wire logic [sram_host_pkg::ADDR_W-1:0] reqAddr,
    input wire logic [sram_host_pkg::DATA_W-1:0] reqWdata,
    input wire logic [sram_host_pkg::LANES-1:0] reqByteEn,
    output logic [sram_host_pkg::DATA_W-1:0] rspRdata,
    output logic rspValid,
    output logic densityMatch,
    output logic [sram_host_pkg::ADDR_W-1:0] addr_lines,
    output logic lane0_select_n,
    output logic lane1_select_n,
    output logic lane2_select_n,
    output logic lane3_select_n,
    output logic writeStrobe_n,
    output logic outputDrive_n,
    input wire logic [sram_host_pkg::DATA_W-1:0] dataIn,
    output logic [sram_host_pkg::DATA_W-1:0] dataOut,
    output logic dataOe_n,
    input wire logic density_strap_0,
    input wire logic density_strap_1
);
    import sram_host_pkg::*;

    logic rstSync1_q;
    logic rstSync2_q;
    logic rst_n;
    regs_t r_q;
    regs_t r_d;
    logic [LANES-1:0] reqByteEnHold;
    logic [LANES-1:0] byteEn_q;
    // Pin view of the lane selects, bit i is lane i
    logic [LANES-1:0] selPins_n;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rstSync1_q <= 1'b0;
            rstSync2_q <= 1'b0;
        end else begin
            rstSync1_q <= 1'b1;
            rstSync2_q <= rstSync1_q;
        end
    end
    assign rst_n = rstSync2_q;

    // Accept only when idle; one access at a time keeps pin timing simple
    assign reqReady = (r_q.state == ST_IDLE);

    always_comb begin
        r_d = r_q;
        r_d.rvalid = 1'b0;
        // Unconnected straps pull high on this density [RULE6]
        r_d.densityOk = ({density_strap_1, density_strap_0} == DENSITY_128K);
        unique case (r_q.state)
            ST_IDLE: begin
                if (reqValid) begin
                    // Address and lanes latched before any select goes low [RULE8] [RULE11]
                    r_d.addr = reqAddr;
                    r_d.wdata = reqWdata;
                    r_d.write = reqWrite;
                    r_d.lanesN = LANES_OFF;
                    r_d.state = ST_SETUP;
                end
            end
            ST_SETUP: begin
                // Selects assert one cycle after address is stable [RULE8] [RULE5]
                r_d.lanesN = r_q.write ? ~reqByteEnHold : LANES_OFF ^ LANES_OFF;
                if (r_q.write) begin
                    r_d.weN = 1'b0;
                    r_d.dataOeN = 1'b0;
                    r_d.cnt = CNT_WP;
                    r_d.state = ST_WRITE;
                end else begin
                    // All lanes read; output drive low with strobe high [RULE3]
                    r_d.oeN = 1'b0;
                    r_d.cnt = CNT_READ;
                    r_d.state = ST_READ;
                end
            end
            ST_WRITE: begin
                // Address and lanes held for the whole strobe-low time [RULE12] [RULE2]
                if (r_q.cnt == CNT_ONE) begin
                    // Strobe rises first, ending the write [RULE7]
                    r_d.weN = 1'b1;
                    r_d.cnt = CNT_HZ;
                    r_d.state = ST_TURN;
                end else begin
                    r_d.cnt = r_q.cnt - CNT_ONE;
                end
            end
            ST_READ: begin
                if (r_q.cnt == CNT_ONE) begin
                    r_d.rdata = dataIn;
                    r_d.rvalid = 1'b1;
                    r_d.oeN = 1'b1;
                    r_d.lanesN = LANES_OFF;
                    r_d.cnt = CNT_HZ;
                    r_d.state = ST_TURN;
                end else begin
                    r_d.cnt = r_q.cnt - CNT_ONE;
                end
            end
            ST_TURN: begin
                // Module floats after deselect before the bus is reused [RULE4]
                r_d.dataOeN = 1'b1;
                r_d.lanesN = LANES_OFF;
                if (r_q.cnt <= CNT_ONE) begin
                    r_d.cnt = CNT_ZERO;
                    r_d.state = ST_IDLE;
                end else begin
                    r_d.cnt = r_q.cnt - CNT_ONE;
                end
            end
            default: r_d.state = ST_IDLE;
        endcase
    end

    // Lane enables captured at the take and held until the next one
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            byteEn_q <= LANES_OFF;
        end else if (reqValid && reqReady) begin
            byteEn_q <= reqByteEn;
        end
    end
    assign reqByteEnHold = byteEn_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            r_q <= '0;
            r_q.state <= ST_IDLE;
            r_q.lanesN <= LANES_OFF;
            r_q.weN <= 1'b1;
            r_q.oeN <= 1'b1;
            r_q.dataOeN <= 1'b1;
        end else begin
            r_q <= r_d;
        end
    end

    assign addr_lines = r_q.addr;
    assign lane0_select_n = r_q.lanesN[0];
    assign lane1_select_n = r_q.lanesN[1];
    assign lane2_select_n = r_q.lanesN[2];
    assign lane3_select_n = r_q.lanesN[3];
    assign writeStrobe_n = r_q.weN;
    assign outputDrive_n = r_q.oeN;
    assign dataOut = r_q.wdata;
    assign dataOe_n = r_q.dataOeN;
    assign rspRdata = r_q.rdata;
    assign rspValid = r_q.rvalid;
    assign densityMatch = r_q.densityOk;
    assign selPins_n = {lane3_select_n, lane2_select_n, lane1_select_n, lane0_select_n};

    sequence writeOpen_s;
        !writeStrobe_n && !dataOe_n;
    endsequence

    // Strobe rises with data still driven, then data and selects let go together
    sequence writeClose_s;
        writeStrobe_n && !dataOe_n ##1 dataOe_n && (&selPins_n);
    endsequence

    strobe_width_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE2]
        $fell(writeStrobe_n) |-> (!writeStrobe_n)[*1] ##1 writeStrobe_n)
        else $error("Write strobe width wrong");
    write_drive_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE2]
        !writeStrobe_n |-> writeOpen_s and ((&selPins_n) == 1'b0 || reqByteEnHold == '0))
        else $error("Write without data drive");
    lanes_match_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE2]
        !writeStrobe_n |-> selPins_n == ~reqByteEnHold)
        else $error("Write selects differ from byte enables");
    idle_quiet_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE2]
        reqReady |-> (&selPins_n) && writeStrobe_n && outputDrive_n && dataOe_n)
        else $error("Pins active while idle");
    read_lanes_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE3]
        !outputDrive_n |-> selPins_n == '0)
        else $error("Read without all lanes selected");
    rsp_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE3]
        rspValid |=> !rspValid)
        else $error("Read response longer than one cycle");
    read_mode_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE3]
        !outputDrive_n |-> writeStrobe_n && dataOe_n)
        else $error("Read with strobe or drive active");
    no_contend_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE4]
        $rose(outputDrive_n) |-> dataOe_n [*2])
        else $error("Bus driven during turnaround");
    addr_stable_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE12]
        !writeStrobe_n |-> $stable(addr_lines) ##1 $stable(addr_lines) && $stable(selPins_n))
        else $error("Address moved during write");
    read_setup_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE8]
        $fell(outputDrive_n) |-> $stable(addr_lines))
        else $error("Address changed with read start");
    write_close_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE7]
        $rose(writeStrobe_n) |-> selPins_n == ~reqByteEnHold ##0 writeClose_s)
        else $error("Write not ended by the strobe");
    addr_first_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE8]
        $fell(lane0_select_n) |-> $stable(addr_lines))
        else $error("Address changed with select");
    strobe_ends_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE7]
        $rose(writeStrobe_n) |-> !dataOe_n ##1 dataOe_n)
        else $error("Data released before strobe end");
    read_resp_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE9]
        $fell(outputDrive_n) |-> ##1 rspValid)
        else $error("Read data not returned");
endmodule : sram_host_ctrl

// >>> common/sram_host_pkg.sv
// Constants and types for the 128K x 32 asynchronous SRAM module host controller
// How it works
// RULE1: The module stores 131,072 random-access words of 32 bits each.
// RULE2: A write happens while write strobe and a lane select are both low.
// RULE3: A read happens with write strobe high, lane select and output drive low.
// RULE4: Module data lines float whenever select or output drive is high.
// RULE5: Four active-low lane selects each enable one byte lane independently.
// RULE6: Both density strap pins are unconnected on the module.
// RULE7: Write is bounded by later assert and earlier deassert of select or strobe.
// RULE8: Address must be valid no later than the last lane select going active.
// RULE9: Address-controlled reads keep selects low and get new data per address.
// RULE10: Low-power module gates strobe, output drive and address while deselected.
// RULE11: The module decodes a 17-bit word address, lowest bit first.
// RULE12: Address and lane selects stay stable while the write strobe is low.
package sram_host_pkg;
    localparam int ADDR_W = 17;
    localparam int DATA_W = 32;
    localparam int LANES = 4;
    localparam int CLK_PERIOD_NS = 40;
    // Slowest speed grade figures
    localparam int T_RC_NS = 35;
    localparam int T_WP_NS = 20;
    localparam int T_AS_NS = 0;
    localparam int T_AH_NS = 0;
    localparam int T_HZ_NS = 15;
    localparam int READ_CYC = (T_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HZ_CYC = (T_HZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_READ = CNT_W'(READ_CYC);
    localparam logic [CNT_W-1:0] CNT_WP = CNT_W'(WP_CYC);
    localparam logic [CNT_W-1:0] CNT_HZ = CNT_W'(HZ_CYC);
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [LANES-1:0] LANES_OFF = 4'hF;
    localparam logic [1:0] DENSITY_128K = 2'h3;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b0_0001,
        ST_SETUP = 5'b0_0010,
        ST_WRITE = 5'b0_0100,
        ST_READ = 5'b0_1000,
        ST_TURN = 5'b1_0000
    } state_t;

    typedef struct packed {
        state_t state;
        logic [CNT_W-1:0] cnt;
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [LANES-1:0] lanesN;
        logic weN;
        logic oeN;
        logic dataOeN;
        logic [DATA_W-1:0] rdata;
        logic rvalid;
        logic densityOk;
    } regs_t;
endpackage : sram_host_pkg

// >>> test/sram_module_model.sv
// Behavioural model of the 128K x 32 asynchronous SRAM module
`timescale 1ns/100ps
module sram_module_model (
    input wire logic [16:0] addr_lines,
    input wire logic [3:0] selN,
    input wire logic writeStrobe_n,
    input wire logic outputDrive_n,
    input wire logic hostOe_n,
    input wire logic [31:0] hostData,
    output logic [31:0] busLevel,
    output logic density_strap_0,
    output logic density_strap_1
);
    logic [31:0] mem [0:131071];
    logic [31:0] lastBus = 32'h0000_0000;
    logic [3:0] drv;
    assign density_strap_0 = 1'b1; // Unconnected pin, host pull-up reads high
    assign density_strap_1 = 1'b1;
    always @* begin
        for (int i = 0; i < 4; i++) begin
            drv[i] = !selN[i] && !outputDrive_n && writeStrobe_n; // Gated while deselected
            if (!hostOe_n) busLevel[8*i+:8] = hostData[8*i+:8];
            else if (drv[i]) busLevel[8*i+:8] = mem[addr_lines][8*i+:8];
            else busLevel[8*i+:8] = ~lastBus[8*i+:8]; // Floating lane must not mimic stale data
            if (!hostOe_n || drv[i]) lastBus[8*i+:8] = busLevel[8*i+:8];
            if (!writeStrobe_n && !selN[i]) mem[addr_lines][8*i+:8] = busLevel[8*i+:8];
        end
    end
endmodule : sram_module_model

// >>> test/async_sram_module_128k_x32_tb_top.sv
// Testbench for the SRAM module host controller
`timescale 1ns/100ps
module async_sram_module_128k_x32_tb_top;
    import sram_host_pkg::*;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic reqValid = 1'b0;
    logic reqWrite = 1'b0;
    logic [16:0] reqAddr = 17'h0_0000;
    logic [31:0] reqWdata = 32'h0000_0000;
    logic [3:0] reqByteEn = 4'h0;
    logic reqReady, rspValid, densityMatch, writeStrobe_n, outputDrive_n, dataOe_n, strap0, strap1;
    wire [3:0] selN;
    logic [31:0] rspRdata, dataOut, busLevel, q;
    logic [16:0] addr_lines;
    logic [31:0] shadow [int];
    int n_fail = 0;
    int checked = 0;
    int cycles = 0;

    sram_host_ctrl dut (.clk_sys(clk_sys), .arst_n(arst_n), .reqValid(reqValid), .reqReady(reqReady),
        .reqWrite(reqWrite), .reqAddr(reqAddr), .reqWdata(reqWdata), .reqByteEn(reqByteEn),
        .rspRdata(rspRdata), .rspValid(rspValid), .densityMatch(densityMatch), .addr_lines(addr_lines),
        .lane0_select_n(selN[0]), .lane1_select_n(selN[1]), .lane2_select_n(selN[2]),
        .lane3_select_n(selN[3]), .writeStrobe_n(writeStrobe_n), .outputDrive_n(outputDrive_n),
        .dataIn(busLevel), .dataOut(dataOut), .dataOe_n(dataOe_n), .density_strap_0(strap0),
        .density_strap_1(strap1));
    sram_module_model model (.addr_lines(addr_lines), .selN(selN), .writeStrobe_n(writeStrobe_n),
        .outputDrive_n(outputDrive_n), .hostOe_n(dataOe_n), .hostData(dataOut), .busLevel(busLevel),
        .density_strap_0(strap0), .density_strap_1(strap1));

    always #20 clk_sys = ~clk_sys;
    // Whole run needs well under 1000 cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            finish_test();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic access(input logic wr, input logic [16:0] a, input logic [31:0] d, input logic [3:0] be);
        logic [3:0] lanesLow;
        logic weLow;
        logic badAddr;
        logic oeLow;
        int n;
        int nValid;
        lanesLow = 4'h0;
        weLow = 1'b0;
        badAddr = 1'b0;
        oeLow = 1'b0;
        nValid = 0;
        q = 32'hxxxx_xxxx;
        @(negedge clk_sys);
        for (n = 0; n < 20 && reqReady !== 1'b1; n++) @(negedge clk_sys);
        reqValid = 1'b1;
        reqWrite = wr;
        reqAddr = a;
        reqWdata = d;
        reqByteEn = be;
        @(negedge clk_sys);
        reqValid = 1'b0;
        for (n = 0; n < 10 && reqReady !== 1'b1; n++) begin
            lanesLow = lanesLow | ~selN;
            weLow = weLow | !writeStrobe_n;
            oeLow = oeLow | !outputDrive_n;
            if (selN !== 4'hF && addr_lines !== a) badAddr = 1'b1;
            if (rspValid === 1'b1) begin
                q = rspRdata;
                nValid++;
            end
            @(negedge clk_sys);
        end
        check(32'(weLow), 32'(wr));
        check(32'(oeLow), 32'(!wr));
        check(32'(nValid), wr ? 32'h0000_0000 : 32'h0000_0001);
        check(32'(lanesLow), wr ? 32'(be) : 32'h0000_000F);
        check(32'(badAddr), 32'h0000_0000);
        if (!shadow.exists(int'(a))) shadow[int'(a)] = 32'h0000_0000;
        for (n = 0; n < 4; n++) if (wr && be[n]) shadow[int'(a)][8*n+:8] = d[8*n+:8];
        if (!wr) check(q, shadow[int'(a)]);
    endtask : access

    task automatic t_idle();
        check({selN, writeStrobe_n, outputDrive_n, dataOe_n, densityMatch, reqReady}, 32'h0000_01FF);
    endtask : t_idle

    task automatic t_corners();
        logic [16:0] addrs [4] = '{17'h0_0000, 17'h1_FFFF, 17'h1_0000, 17'h0_5A5A};
        foreach (addrs[i]) access(1'b1, addrs[i], 32'hA5C3_0000 ^ 32'(addrs[i]), 4'hF);
        foreach (addrs[i]) access(1'b0, addrs[i], 32'h0000_0000, 4'hF);
    endtask : t_corners

    task automatic t_lanes();
        access(1'b1, 17'h0_1234, 32'h1111_1111, 4'hF);
        for (int i = 0; i < 4; i++) begin
            access(1'b1, 17'h0_1234, 32'hEEEE_EEEE << (i * 4), 4'(1 << i));
            access(1'b0, 17'h0_1234, 32'h0000_0000, 4'hF);
        end
        // A write with no lane enabled must leave every byte untouched
        access(1'b1, 17'h0_1234, 32'h0000_0000, 4'h0);
        access(1'b0, 17'h0_1234, 32'h0000_0000, 4'hF);
    endtask : t_lanes

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : finish_test

    initial begin
        repeat (10) @(negedge clk_sys);
        arst_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        t_idle();
        t_corners();
        t_lanes();
        t_idle();
        finish_test();
    end
endmodule : async_sram_module_128k_x32_tb_top
